// *** verilog/psa_pkg.sv ***
package psa_pkg;

  // ==========================================================
  // Widths
  localparam int unsigned DATA_W = 128;
  localparam int unsigned CHUNK_W = 64;
  localparam int unsigned NCHUNK = 2;
  localparam int unsigned IMM_W = 8;
  localparam logic [IMM_W-1:0] MAX_SHIFT = 8'h0f;

  // ==========================================================
  // Operation select
  typedef enum logic [4:0] {
    OP_MAX_SW,
    OP_MIN_SW,
    OP_MAX_UB,
    OP_MIN_UB,
    OP_MULH_UW,
    OP_MULH_SW,
    OP_SAD_UB,
    OP_AVG_UB,
    OP_AVG_UW,
    OP_MADD_WD,
    OP_UNSIGNED_DOUBLEWORD_MULTIPLY,
    OP_QUADWORD_ADD,
    OP_QUADWORD_SUBTRACT,
    OP_SHL_BYTES,
    OP_SHR_BYTES
  } psa_op_e;

  // Width mode: 64-bit keeps the low result chunk only
  typedef enum logic {
    MODE_64,
    MODE_128
  } psa_mode_e;

  localparam logic [DATA_W-1:0] ZERO_RES = 128'h0;

endpackage : psa_pkg

// *** verilog/psa_if.sv ***
`timescale 1ns/1ps

// ==========================================================
// Issue bundle between top and lane datapath
interface psa_if;
  import psa_pkg::*;
  psa_op_e op;
  psa_mode_e mode;
  logic [IMM_W-1:0] imm;
  logic [DATA_W-1:0] dst;
  logic [DATA_W-1:0] src;
  logic [DATA_W-1:0] res;

  modport top (output op, output mode, output imm, output dst, output src,
    input res);
  modport core (input op, input mode, input imm, input dst, input src,
    output res);
endinterface : psa_if

// *** verilog/psa_core.sv ***
`timescale 1ns/1ps

// Combinational packed datapath
module psa_core (
  psa_if.core bus
);
  import psa_pkg::*;

  // ==========================================================
  // Helpers
  // Operands widened first so no tool truncates the product
  function automatic logic [31:0] smul(input logic [15:0] a,
                                       input logic [15:0] b);
    return 32'($signed(a)) * 32'($signed(b));
  endfunction : smul

  function automatic logic [15:0] mulh(input logic [15:0] a,
                                       input logic [15:0] b,
                                       input logic sgn);
    logic [31:0] p;
    p = 32'h0;
    if (sgn) begin
      p = smul(a, b);
    end else begin
      p = 32'(a) * 32'(b);
    end
    return p[31:16];
  endfunction : mulh

  function automatic logic [7:0] absdiff(input logic [7:0] a,
                                         input logic [7:0] b);
    return (a > b) ? 8'(a - b) : 8'(b - a);
  endfunction : absdiff

  logic [DATA_W-1:0] r;
  logic [15:0] sad;
  logic [16:0] sb;
  logic [8:0] bb;
  logic [31:0] ma;
  logic [255:0] wide;

  always_comb begin
    r = ZERO_RES;
    sad = 16'h0;
    sb = 17'h0;
    bb = 9'h0;
    ma = 32'h0;
    wide = 256'h0;
    case (bus.op)
      OP_MAX_SW, OP_MIN_SW: begin
        for (int i = 0; i < 8; i++) begin
          // RL1 RL2 signed word compare
          if (($signed(bus.dst[i*16+:16]) > $signed(bus.src[i*16+:16]))
              == (bus.op == OP_MAX_SW)) begin
            r[i*16+:16] = bus.dst[i*16+:16];
          end else begin
            r[i*16+:16] = bus.src[i*16+:16];
          end
        end
      end
      OP_MAX_UB, OP_MIN_UB: begin
        for (int i = 0; i < 16; i++) begin
          // RL3 RL4 unsigned byte compare
          if ((bus.dst[i*8+:8] > bus.src[i*8+:8]) == (bus.op == OP_MAX_UB))
          begin
            r[i*8+:8] = bus.dst[i*8+:8];
          end else begin
            r[i*8+:8] = bus.src[i*8+:8];
          end
        end
      end
      OP_MULH_UW, OP_MULH_SW: begin
        for (int i = 0; i < 8; i++) begin
          // RL5 RL6 variant by opcode, upper half
          r[i*16+:16] = mulh(bus.dst[i*16+:16], bus.src[i*16+:16],
                             bus.op == OP_MULH_SW);
        end
      end
      OP_SAD_UB: begin
        for (int c = 0; c < NCHUNK; c++) begin
          sad = 16'h0;
          for (int i = 0; i < 8; i++) begin
            // RL7 per-byte absolute difference
            sad = sad + 16'(absdiff(bus.dst[c*64+i*8+:8],
                                     bus.src[c*64+i*8+:8]));
          end
          // RL8 low word holds sum, rest zero
          r[c*64+:64] = {48'h0, sad};
        end
      end
      OP_AVG_UB: begin
        for (int i = 0; i < 16; i++) begin
          // RL9 sum with carry-in of one
          bb = 9'(bus.dst[i*8+:8]) + 9'(bus.src[i*8+:8]) + 9'h1;
          // RL10 RL11 RL12 shift, carry fills top bit
          r[i*8+:8] = bb[8:1];
        end
      end
      OP_AVG_UW: begin
        for (int i = 0; i < 8; i++) begin
          // RL9 sum with carry-in of one
          sb = 17'(bus.dst[i*16+:16]) + 17'(bus.src[i*16+:16]) + 17'h1;
          // RL10 RL11 RL12 shift, carry fills top bit
          r[i*16+:16] = sb[16:1];
        end
      end
      OP_MADD_WD: begin
        for (int i = 0; i < 4; i++) begin
          // RL13 signed pair products summed
          ma = smul(bus.dst[i*32+:16], bus.src[i*32+:16])
             + smul(bus.dst[i*32+16+:16], bus.src[i*32+16+:16]);
          r[i*32+:32] = ma;
        end
      end
      OP_UNSIGNED_DOUBLEWORD_MULTIPLY: begin
        for (int c = 0; c < NCHUNK; c++) begin
          // RL14 RL15 low dwords, full product
          r[c*64+:64] = 64'(bus.dst[c*64+:32]) * 64'(bus.src[c*64+:32]);
        end
      end
      OP_QUADWORD_ADD, OP_QUADWORD_SUBTRACT: begin
        for (int c = 0; c < NCHUNK; c++) begin
          // RL17 RL18 sign-agnostic, wraps at 64 bits
          if (bus.op == OP_QUADWORD_ADD) begin
            r[c*64+:64] = bus.dst[c*64+:64] + bus.src[c*64+:64];
          end else begin
            r[c*64+:64] = bus.dst[c*64+:64] - bus.src[c*64+:64];
          end
        end
      end
      OP_SHL_BYTES, OP_SHR_BYTES: begin
        // RL21 oversize count clears all
        if (bus.imm > MAX_SHIFT) begin
          r = ZERO_RES;
        end else if (bus.op == OP_SHL_BYTES) begin
          // RL19 RL20 zero fill low bytes
          r = bus.dst << {bus.imm[3:0], 3'h0};
        end else begin
          // RL19 RL20 zero fill high bytes
          r = bus.dst >> {bus.imm[3:0], 3'h0};
        end
      end
      default: begin
        r = ZERO_RES;
      end
    endcase
    // RL16 64-bit mode keeps one chunk only
    if (bus.mode == MODE_64) begin
      r[DATA_W-1:CHUNK_W] = 64'h0;
    end
  end

  assign bus.res = r;

endmodule : psa_core

// *** verilog/psa_alu.sv ***
`timescale 1ns/1ps

// ==========================================================
// Contract
// RL1 - Signed word max per lane
// RL2 - Signed word min per lane
// RL3 - Unsigned byte max per lane
// RL4 - Unsigned byte min per lane
// RL5 - High multiply, signedness from opcode
// RL6 - Keep upper 16 product bits
// RL7 - Absolute byte differences
// RL8 - Sum into low word, upper cleared
// RL9 - Average adds with carry-in one
// RL10 - Average shifts each sum right once
// RL11 - Carry-out fills element top bit
// RL12 - Byte and word average variants
// RL13 - Word multiply-add into doublewords
// RL14 - Multiply low dwords unsigned
// RL15 - Full 64-bit product written
// RL16 - 128-bit mode does two chunks
// RL17 - Quadword add/subtract, sign agnostic
// RL18 - Quadword result wraps, no flag
// RL19 - Whole-register byte shift by immediate
// RL20 - Vacated bytes filled with zero
// RL21 - Count above 15 gives zero
// RL22 - Result valid one clock after issue
// RL23 - Reset clears valid and result
module psa_alu (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Issue
  input wire logic issue_valid_i,
  input wire psa_pkg::psa_op_e op_i,
  input wire psa_pkg::psa_mode_e mode_i,
  input wire logic [psa_pkg::IMM_W-1:0] imm_i,
  input wire logic [psa_pkg::DATA_W-1:0] dst_i,
  input wire logic [psa_pkg::DATA_W-1:0] src_i,
  // Result
  output logic res_valid_o,
  output logic [psa_pkg::DATA_W-1:0] res_o
);
  import psa_pkg::*;

  // ==========================================================
  // Datapath
  psa_if bus ();

  assign bus.op = op_i;
  assign bus.mode = mode_i;
  assign bus.imm = imm_i;
  assign bus.dst = dst_i;
  assign bus.src = src_i;

  psa_core u_core (
    .bus(bus)
  );

  // ==========================================================
  // Result register
  logic valid_ff;
  logic nxt_valid;
  logic [DATA_W-1:0] res_ff;
  logic [DATA_W-1:0] nxt_res;

  always_comb begin
    // RL22 capture on issue, hold otherwise
    nxt_valid = issue_valid_i;
    nxt_res = issue_valid_i ? bus.res : res_ff;
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      // RL23 idle, zero result
      valid_ff <= 1'b0;
      res_ff <= ZERO_RES;
    end else begin
      valid_ff <= nxt_valid;
      res_ff <= nxt_res;
    end
  end

  assign res_valid_o = valid_ff;
  assign res_o = res_ff;

endmodule : psa_alu

// *** tb/psa_alu_monitor.sv ***
`timescale 1ns/1ps
// ========================================
// Result timing and arithmetic checks
module psa_alu_monitor (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic issue_valid_i,
  input wire psa_pkg::psa_op_e op_i,
  input wire psa_pkg::psa_mode_e mode_i,
  input wire logic [7:0] imm_i,
  input wire logic [127:0] dst_i,
  input wire logic [127:0] src_i,
  input wire logic res_valid_o,
  input wire logic [127:0] res_o
);
  import psa_pkg::*;
  logic [127:0] qadd, umul;
  logic w;
  assign qadd = {dst_i[127:64]+src_i[127:64], dst_i[63:0]+src_i[63:0]};
  assign umul = {64'(dst_i[95:64])*src_i[95:64],
    64'(dst_i[31:0])*src_i[31:0]};
  assign w = issue_valid_i && mode_i == MODE_128;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  a_valid_next: assert property (issue_valid_i |=> res_valid_o)
    else $error("result valid missing");
  a_valid_only: assert property (!issue_valid_i |=> !res_valid_o)
    else $error("result valid without issue");
  a_res_held: assert property (!issue_valid_i |=> $stable(res_o))
    else $error("idle result changed");
  a_qadd_wrap: assert property (
    w && op_i == OP_QUADWORD_ADD |=> res_o == $past(qadd))
    else $error("quadword sum wrong");
  a_udq_full: assert property (
    w && op_i == OP_UNSIGNED_DOUBLEWORD_MULTIPLY |=> res_o == $past(umul))
    else $error("doubleword product wrong");
  a_shift_zero: assert property (
    issue_valid_i && imm_i > 8'h0f && op_i inside {OP_SHL_BYTES,
    OP_SHR_BYTES} |=> res_o == '0) else $error("long shift not zero");
  a_half_zero: assert property (
    issue_valid_i && mode_i == MODE_64 |=> res_o[127:64] == '0)
    else $error("narrow mode upper half set");
  a_sad_clear: assert property (
    issue_valid_i && op_i == OP_SAD_UB |=> res_o[63:16] == '0)
    else $error("sad upper words set");
  c_back2back: cover property (issue_valid_i ##1 issue_valid_i);
  c_long_shift: cover property (issue_valid_i && imm_i > 8'h0f);
  c_idle: cover property (res_valid_o ##1 !res_valid_o);
endmodule : psa_alu_monitor

bind psa_alu psa_alu_monitor psa_alu_monitor_inst (.*);

// *** tb/psa_issuer.sv ***
`timescale 1ns/1ps
// ========================================
// Issuing pipeline, drives at falling edge
module psa_issuer (
  input wire logic clk_i,
  output logic vld_o = 1'b0,
  output psa_pkg::psa_op_e op_o = psa_pkg::OP_MAX_SW,
  output psa_pkg::psa_mode_e mode_o = psa_pkg::MODE_128,
  output logic [7:0] imm_o = 8'h00,
  output logic [127:0] dst_o = 128'h0,
  output logic [127:0] src_o = 128'h0
);
  import psa_pkg::*;
  task automatic send(input psa_op_e o, input psa_mode_e m,
    input logic [7:0] k, input logic [127:0] d, input logic [127:0] s);
    @(negedge clk_i);
    vld_o = 1'b1;
    op_o = o;
    mode_o = m;
    imm_o = k;
    dst_o = d;
    src_o = s;
  endtask : send
  // Released operands scrambled so stale data cannot pass
  task automatic idle;
    @(negedge clk_i);
    vld_o = 1'b0;
    dst_o = ~dst_o;
    src_o = ~src_o;
  endtask : idle
endmodule : psa_issuer

// *** tb/psa_alu_tb.sv ***
`timescale 1ns/1ps
// ========================================
// Randomised op sweep against reference
module psa_alu_tb;
  import psa_pkg::*;
  logic ref_clk, nrst, vld, res_valid;
  psa_op_e op;
  psa_mode_e mode;
  logic [7:0] imm;
  logic [127:0] dst, src, res;
  logic [127:0] exp_q[$];
  int error_cnt = 0;
  int comparisons = 0;
  psa_op_e ops[15] = '{OP_MAX_SW, OP_MIN_SW, OP_MAX_UB, OP_MIN_UB,
    OP_MULH_UW, OP_MULH_SW, OP_SAD_UB, OP_AVG_UB, OP_AVG_UW, OP_MADD_WD,
    OP_UNSIGNED_DOUBLEWORD_MULTIPLY, OP_QUADWORD_ADD, OP_QUADWORD_SUBTRACT,
    OP_SHL_BYTES, OP_SHR_BYTES};
  psa_issuer psa_issuer_inst (.clk_i(ref_clk), .vld_o(vld), .op_o(op),
    .mode_o(mode), .imm_o(imm), .dst_o(dst), .src_o(src));
  psa_alu psa_alu_inst (.ref_clk_i(ref_clk), .nrst_i(nrst),
    .issue_valid_i(vld), .op_i(op), .mode_i(mode), .imm_i(imm),
    .dst_i(dst), .src_i(src), .res_valid_o(res_valid), .res_o(res));
  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;
  function automatic logic [127:0] ref_res(psa_op_e o, psa_mode_e m,
    logic [7:0] k, logic [127:0] a, logic [127:0] b);
    logic [127:0] r;
    logic [15:0] x, y;
    logic [31:0] p;
    int sx, sy;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      x = a[i*8+:8];
      y = b[i*8+:8];
      case (o)
        OP_MIN_UB: r[i*8+:8] = 8'(x < y ? x : y);
        OP_MAX_UB: r[i*8+:8] = 8'(x > y ? x : y);
        // Wide sum keeps the carry for the top bit
        OP_AVG_UB: r[i*8+:8] = 8'((x + y + 16'h1) >> 1);
        OP_SAD_UB: r[i/8*64+:16] += x > y ? x - y : y - x;
        default: ;
      endcase
      x = a[i/2*16+:16];
      y = b[i/2*16+:16];
      sx = $signed(x);
      sy = $signed(y);
      p = 32'(x) * 32'(y);
      case (o)
        OP_MAX_SW: r[i/2*16+:16] = sx > sy ? x : y;
        OP_MIN_SW: r[i/2*16+:16] = sx < sy ? x : y;
        OP_MULH_UW: r[i/2*16+:16] = p[31:16];
        OP_MULH_SW: r[i/2*16+:16] = 16'((sx * sy) >>> 16);
        // Carry kept by evaluating in 32 bits
        OP_AVG_UW: r[i/2*16+:16] = 16'((32'(x) + 32'(y) + 32'h1) >> 1);
        // Each word visited twice; add its product once
        OP_MADD_WD: if (i % 2 == 0) r[i/4*32+:32] += 32'(sx * sy);
        default: ;
      endcase
    end
    for (int c = 0; c < 128; c += 64) begin
      case (o)
        OP_QUADWORD_ADD: r[c+:64] = a[c+:64] + b[c+:64];
        OP_QUADWORD_SUBTRACT: r[c+:64] = a[c+:64] - b[c+:64];
        OP_UNSIGNED_DOUBLEWORD_MULTIPLY: r[c+:64] = a[c+:32] * b[c+:32];
        OP_SHL_BYTES: r = k > 8'h0f ? '0 : a << {k, 3'h0};
        OP_SHR_BYTES: r = k > 8'h0f ? '0 : a >> {k, 3'h0};
        default: ;
      endcase
    end
    if (m == MODE_64) begin
      r[127:64] = '0;
    end
    return r;
  endfunction : ref_res
  task automatic cmp_res(input logic [127:0] e, input logic [127:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: exp %h got %h", $time, e, g);
    end
  endtask : cmp_res
  task automatic report_and_stop;
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  always @(negedge ref_clk) begin
    if (res_valid === 1'b1)
      cmp_res(exp_q.size() ? exp_q.pop_front() : ~res, res);
  end
  initial begin
    logic [127:0] d, s;
    psa_mode_e m;
    logic [7:0] k;
    nrst = 1'b0;
    void'($urandom(32'h00cf));
    repeat (16) @(negedge ref_clk);
    nrst = 1'b1;
    @(negedge ref_clk);
    cmp_res(ZERO_RES, res);
    cmp_res(128'h0, 128'(res_valid));
    foreach (ops[j]) begin
      repeat (8) begin
        d = {$urandom(), $urandom(), $urandom(), $urandom()};
        s = {$urandom(), $urandom(), $urandom(), $urandom()};
        m = psa_mode_e'($urandom_range(1));
        k = 8'($urandom_range(31));
        exp_q.push_back(ref_res(ops[j], m, k, d, s));
        psa_issuer_inst.send(ops[j], m, k, d, s);
      end
    end
    psa_issuer_inst.idle();
    repeat (3) @(negedge ref_clk);
    cmp_res(128'(exp_q.size()), ZERO_RES);
    report_and_stop();
  end
  initial begin
    #(100 * 2000);
    error_cnt++;
    report_and_stop();
  end
endmodule : psa_alu_tb
